/* dac_feed_regs.svh */
/*
 Register offsets, field positions, reset values and timing counts of the
 stereo sample feed. Assumes a 32-bit AXI4-Lite word per register.
*/
`ifndef DAC_FEED_REGS_SVH
`define DAC_FEED_REGS_SVH

`define DAC_OFFSET_CONTROL 8'h00
`define DAC_OFFSET_SAMPLE 8'h04
`define DAC_OFFSET_STATUS 8'h08
`define DAC_OFFSET_IRQ_ENABLE 8'h0C

`define DAC_BIT_ENABLE 0
`define DAC_BIT_TX_READY 0
`define DAC_BIT_UNDERRUN 1

`define DAC_RESET_CONTROL 32'h0000_0000
`define DAC_RESET_SAMPLE 32'h0000_0000
`define DAC_RESET_IRQ_ENABLE 2'h0

`define DAC_SAMPLE_DIVIDE 256

`endif

/* dac_feed_pkg.sv */
/*
 Types shared by the stereo sample feed.
 Assumes nothing beyond a SystemVerilog compiler.
*/
package dac_feed_pkg;

	typedef enum logic [1:0] {
		RESP_OKAY = 2'b00,
		RESP_SLVERR = 2'b10
	} resp_type;

	typedef logic [15:0] channel_type;

endpackage

/* sample_pacer.sv */
/*
 Sample pacer: counts rising edges of the sample-rate clock and pulses
 take once per output sample period.
 Assumes sample_rate_clock is synchronous to aclk and much slower than it.
*/
`timescale 1ns/1ps
`default_nettype none
`include "dac_feed_regs.svh"

module sample_pacer #(
	parameter int DIVIDE = `DAC_SAMPLE_DIVIDE
) (
	// System
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic ce,
	// Control
	input wire logic run,
	input wire logic sample_rate_clock,
	// Event
	output logic take
);

	localparam int CW = $clog2(DIVIDE);
	localparam logic [CW-1:0] LAST = CW'(DIVIDE - 1);

	logic prev_level;
	logic [CW-1:0] count;
	wire rise = run && sample_rate_clock && !prev_level;
	wire wrap = rise && (count == LAST);

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			prev_level <= 1'b0;
			count <= '0;
			take <= 1'b0;
		end else if (ce) begin
			prev_level <= sample_rate_clock;
			// Stopped pacer restarts a full period on enable
			if (!run) begin
				count <= '0;
			end else if (rise) begin
				count <= wrap ? '0 : count + 1'b1;
			end
			take <= wrap;
		end
	end

	AST_TAKE_PERIOD: assert property (@(posedge aclk) disable iff (!aresetn)
		$rose(take) |-> ($past(count) == LAST) && $past(rise))
		else $error("take without a full sample period");

endmodule

`default_nettype wire

/* stereo_bitstream_dac_feed.sv */
/*
 Stereo bitstream converter sample feed: AXI4-Lite register slave, sample
 holding register, transmit-ready and underrun events, irq and DMA request.
 Assumes sample_rate_clock runs at 256 times the sample rate and is
 synchronous to aclk; the analog stage sits outside.
*/
// The AXI4-Lite interface to the registers and the placing of the registers were chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none
`include "dac_feed_regs.svh"

module stereo_bitstream_dac_feed #(
	parameter int SAMPLE_DIVIDE = `DAC_SAMPLE_DIVIDE,
	parameter int ADDR_WIDTH = 8
) (
	// System
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic ce,
	// Sample pacing
	input wire logic sample_rate_clock,
	// AXI4-Lite write address
	input wire logic awvalid,
	output logic awready,
	input wire logic [ADDR_WIDTH-1:0] awaddr,
	// AXI4-Lite write data
	input wire logic wvalid,
	output logic wready,
	input wire logic [31:0] wdata,
	input wire logic [3:0] wstrb,
	// AXI4-Lite write response
	output logic bvalid,
	input wire logic bready,
	output logic [1:0] bresp,
	// AXI4-Lite read address
	input wire logic arvalid,
	output logic arready,
	input wire logic [ADDR_WIDTH-1:0] araddr,
	// AXI4-Lite read data
	output logic rvalid,
	input wire logic rready,
	output logic [31:0] rdata,
	output logic [1:0] rresp,
	// Converter samples
	output dac_feed_pkg::channel_type left_sample,
	output dac_feed_pkg::channel_type right_sample,
	// Requests
	output logic irq,
	output logic dma_req
);

	function automatic logic reg_hit(input logic [ADDR_WIDTH-1:0] addr, input logic [7:0] offset);
		reg_hit = (addr[ADDR_WIDTH-1:2] == (ADDR_WIDTH-2)'(offset[7:2]));
	endfunction

	// Register state
	logic enable;
	logic [31:0] stereo_sample_word;
	logic pending;
	logic tx_ready;
	logic underrun;
	logic [1:0] irq_enable;
	wire [1:0] irq_status_word = {underrun, tx_ready};

	// Write channel holding
	logic aw_full;
	logic w_full;
	logic [ADDR_WIDTH-1:0] aw_addr_q;
	logic [31:0] wdata_q;
	logic [3:0] wstrb_q;

	wire aw_take = awvalid && awready;
	wire w_take = wvalid && wready;
	wire do_write = aw_full && w_full && !bvalid;
	wire wr_ctrl = do_write && reg_hit(aw_addr_q, `DAC_OFFSET_CONTROL);
	wire wr_sample = do_write && reg_hit(aw_addr_q, `DAC_OFFSET_SAMPLE);
	wire wr_status = do_write && reg_hit(aw_addr_q, `DAC_OFFSET_STATUS);
	wire wr_ier = do_write && reg_hit(aw_addr_q, `DAC_OFFSET_IRQ_ENABLE);
	wire wr_bad = do_write && !(wr_ctrl || wr_sample || wr_status || wr_ier);

	wire next_aw_full = do_write ? 1'b0 : (aw_take ? 1'b1 : aw_full);
	wire next_w_full = do_write ? 1'b0 : (w_take ? 1'b1 : w_full);

	// Byte-lane merge of the sample word
	wire [31:0] merged_sample;
	genvar lane;
	generate
		for (lane = 0; lane < 4; lane++) begin : g_lane
			assign merged_sample[lane*8 +: 8] = wstrb_q[lane] ? wdata_q[lane*8 +: 8]
				: stereo_sample_word[lane*8 +: 8];
		end
	endgenerate

	// Pacing
	logic take;

	sample_pacer #(
		.DIVIDE(SAMPLE_DIVIDE)
	) u_pacer (
		.aclk(aclk),
		.aresetn(aresetn),
		.ce(ce),
		.run(enable),
		.sample_rate_clock(sample_rate_clock),
		.take(take)
	);

	// Sample flow; write and take in one cycle: old sample consumed, new one held
	wire consume = take && pending;
	wire set_underrun = take && !pending;
	wire clear_underrun = wr_status && wstrb_q[0] && wdata_q[`DAC_BIT_UNDERRUN];
	wire next_pending = wr_sample ? 1'b1 : (take ? 1'b0 : pending);
	wire next_tx_ready = wr_sample ? 1'b0 : (consume ? 1'b1 : tx_ready);
	wire next_underrun = set_underrun || (underrun && !clear_underrun);
	wire next_enable = (wr_ctrl && wstrb_q[0]) ? wdata_q[`DAC_BIT_ENABLE] : enable;
	wire [1:0] next_irq_enable = (wr_ier && wstrb_q[0]) ? wdata_q[1:0] : irq_enable;

	// Read path
	wire ar_take = arvalid && arready;
	wire next_rvalid = ar_take ? 1'b1 : ((rvalid && rready) ? 1'b0 : rvalid);
	wire rd_ctrl = reg_hit(araddr, `DAC_OFFSET_CONTROL);
	wire rd_sample = reg_hit(araddr, `DAC_OFFSET_SAMPLE);
	wire rd_status = reg_hit(araddr, `DAC_OFFSET_STATUS);
	wire rd_ier = reg_hit(araddr, `DAC_OFFSET_IRQ_ENABLE);
	wire rd_ok = rd_ctrl || rd_sample || rd_status || rd_ier;
	wire [31:0] rd_value = rd_ctrl ? {31'h0000_0000, enable}
		: rd_sample ? stereo_sample_word
		: rd_status ? {30'h0000_0000, irq_status_word}
		: rd_ier ? {30'h0000_0000, irq_enable}
		: 32'h0000_0000;

	// Write channel handshake
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			aw_full <= 1'b0;
			w_full <= 1'b0;
			awready <= 1'b0;
			wready <= 1'b0;
			aw_addr_q <= '0;
			wdata_q <= 32'h0000_0000;
			wstrb_q <= 4'h0;
		end else if (ce) begin
			aw_full <= next_aw_full;
			w_full <= next_w_full;
			awready <= !next_aw_full;
			wready <= !next_w_full;
			if (aw_take) begin
				aw_addr_q <= awaddr;
			end
			if (w_take) begin
				wdata_q <= wdata;
				wstrb_q <= wstrb;
			end
		end
	end

	// Write response
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			bvalid <= 1'b0;
			bresp <= dac_feed_pkg::RESP_OKAY;
		end else if (ce) begin
			if (do_write) begin
				bvalid <= 1'b1;
				bresp <= wr_bad ? dac_feed_pkg::RESP_SLVERR : dac_feed_pkg::RESP_OKAY;
			end else if (bready) begin
				bvalid <= 1'b0;
			end
		end
	end

	// Read response; reads have no side effects
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			arready <= 1'b0;
			rvalid <= 1'b0;
			rdata <= 32'h0000_0000;
			rresp <= dac_feed_pkg::RESP_OKAY;
		end else if (ce) begin
			arready <= !next_rvalid;
			rvalid <= next_rvalid;
			if (ar_take) begin
				rdata <= rd_value;
				rresp <= rd_ok ? dac_feed_pkg::RESP_OKAY : dac_feed_pkg::RESP_SLVERR;
			end
		end
	end

	// Control and sample registers
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			enable <= 1'(`DAC_RESET_CONTROL >> `DAC_BIT_ENABLE);
			irq_enable <= `DAC_RESET_IRQ_ENABLE;
			stereo_sample_word <= `DAC_RESET_SAMPLE;
		end else if (ce) begin
			enable <= next_enable;
			irq_enable <= next_irq_enable;
			if (wr_sample) begin
				stereo_sample_word <= merged_sample;
			end
		end
	end

	// Sample consumption and events; underrun set beats its clear
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			pending <= 1'b0;
			tx_ready <= 1'b1;
			underrun <= 1'b0;
			left_sample <= 16'h0000;
			right_sample <= 16'h0000;
		end else if (ce) begin
			pending <= next_pending;
			tx_ready <= next_tx_ready;
			underrun <= next_underrun;
			// On underrun the converter repeats the last sample
			if (consume) begin
				left_sample <= stereo_sample_word[15:0];
				right_sample <= stereo_sample_word[31:16];
			end
		end
	end

	// Request outputs
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			irq <= 1'b0;
			dma_req <= 1'b0;
		end else if (ce) begin
			irq <= |(irq_status_word & irq_enable);
			dma_req <= next_enable && next_tx_ready;
		end
	end

	default clocking cb @(posedge aclk);
	endclocking
	default disable iff (!aresetn);

	sequence s_write_alone;
		ce && wr_sample && !take;
	endsequence

	sequence s_mask_off;
		(ce && irq_enable == 2'h0)[*2];
	endsequence

	AST_STEREO_LOAD: assert property ((ce && wr_sample && wstrb_q == 4'hF) |=>
		stereo_sample_word == $past(wdata_q))
		else $error("sample word not loaded as one unit");

	AST_UNDERRUN_SET: assert property ((ce && take && !pending) |=> underrun)
		else $error("late sample did not set underrun");

	AST_UNDERRUN_DMA: assert property ((ce && take && !pending && !wr_sample) |=>
		underrun && !pending && (tx_ready == $past(tx_ready)))
		else $error("underrun path disturbed sample state");

	AST_TXRDY_CLEAR: assert property (s_write_alone |=> !tx_ready && pending)
		else $error("sample write left transmit-ready set");

	AST_TXRDY_SET: assert property ((ce && consume && !wr_sample) |=>
		tx_ready && ({right_sample, left_sample} == $past(stereo_sample_word)))
		else $error("consumed sample did not raise transmit-ready");

	AST_IRQ_LEVEL: assert property (ce |=>
		irq == |({$past(underrun), $past(tx_ready)} & $past(irq_enable)))
		else $error("irq does not follow enabled status");

	AST_IRQ_MASK: assert property (s_mask_off |-> !irq)
		else $error("irq raised with both sources disabled");

	AST_DMA_ONE: assert property (s_write_alone |=> !dma_req ##0 (!dma_req)[*1])
		else $error("request stayed up after the sample write");

	AST_NO_TAKE_OFF: assert property ((ce && !enable) [*2] |-> !take)
		else $error("sample consumed while disabled");

	// Request only while enabled and the holding register is free
	AST_REQ_LEVEL: assert property (dma_req |-> enable && tx_ready)
		else $error("request raised without room for a sample");

	AST_SAMPLE_PAIR: assert property ((ce && !consume) |=>
		$stable(left_sample) && $stable(right_sample))
		else $error("converter sample moved without a consumption");

	AST_UNDERRUN_STICKY: assert property ((ce && underrun && !clear_underrun) |=> underrun)
		else $error("underrun flag dropped without a clear");

	AST_WRITE_RESP: assert property ((ce && do_write) |=> bvalid)
		else $error("accepted write got no response");

endmodule

`default_nettype wire

/* dac_feed_host.sv */
/*
 Bus-side partner of the sample feed: AXI4-Lite master tasks plus a DMA
 engine that answers dma_req with one sample write, promptly or late.
 Assumes one aclk domain and a single caller of write at a time.
*/
`timescale 1ns/1ps
`default_nettype none

module dac_feed_host (
	// System
	input wire logic aclk,
	// Write channels
	output logic awvalid,
	input wire logic awready,
	output logic [7:0] awaddr,
	output logic wvalid,
	input wire logic wready,
	output logic [31:0] wdata,
	output logic [3:0] wstrb,
	input wire logic bvalid,
	output logic bready,
	input wire logic [1:0] bresp,
	// Read channels
	output logic arvalid,
	input wire logic arready,
	output logic [7:0] araddr,
	input wire logic rvalid,
	output logic rready,
	input wire logic [31:0] rdata,
	input wire logic [1:0] rresp,
	// Request
	input wire logic dma_req
);
	logic dma_on = 1'b0;
	int dma_lag = 0;
	logic [31:0] dma_word = 32'h0000_0000;
	logic [1:0] dma_r;

	initial begin
		{awvalid, wvalid, bready, arvalid, rready} = 5'h00;
		{awaddr, araddr, wdata, wstrb} = 52'h0;
	end

	// Released address and data show their inverse, never the old value; wstrb keeps 4'hF
	task automatic write(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
		logic ta;
		logic tw;
		ta = 1'b0;
		tw = 1'b0;
		@(posedge aclk);
		awvalid <= 1'b1;
		awaddr <= a;
		wvalid <= 1'b1;
		wdata <= d;
		wstrb <= 4'hF;
		bready <= 1'b1;
		while (!(ta && tw)) begin
			@(posedge aclk);
			if (awready === 1'b1 && !ta) begin
				ta = 1'b1;
				awvalid <= 1'b0;
				awaddr <= ~a;
			end
			if (wready === 1'b1 && !tw) begin
				tw = 1'b1;
				wvalid <= 1'b0;
				wdata <= ~d;
			end
		end
		do @(posedge aclk); while (bvalid !== 1'b1);
		r = bresp;
		bready <= 1'b0;
	endtask

	task automatic read(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
		@(posedge aclk);
		arvalid <= 1'b1;
		araddr <= a;
		rready <= 1'b1;
		do @(posedge aclk); while (arready !== 1'b1);
		arvalid <= 1'b0;
		araddr <= ~a;
		do @(posedge aclk); while (rvalid !== 1'b1);
		d = rdata;
		r = rresp;
		rready <= 1'b0;
	endtask

	// One write per request; a lag beyond the period starves the feed
	always begin
		@(posedge aclk);
		if (dma_on && dma_req === 1'b1) begin
			repeat (dma_lag) @(posedge aclk);
			dma_word = dma_word + 32'h0001_0001;
			write(8'h04, dma_word, dma_r);
		end
	end
endmodule

`default_nettype wire

/* test_stereo_bitstream_dac_feed.sv */
/*
 Self-checking bench of the stereo sample feed: reset, sample path,
 underrun, irq masking, unmapped access and DMA streaming.
 Assumes dac_feed_host as bus master and DMA engine.
*/
`timescale 1ns/1ps
`default_nettype none
`include "dac_feed_regs.svh"
`define CHK(n, e, g) begin checked++; if ((g) !== (e)) begin num_errors++; $display("MISMATCH %s exp %h got %h", n, e, g); end end

module test_stereo_bitstream_dac_feed;
	localparam int DIV = 4;
	// Sample clock runs at aclk/4
	localparam int PER = DIV * 4;
	localparam logic [7:0] CTL = `DAC_OFFSET_CONTROL;
	localparam logic [7:0] SMP = `DAC_OFFSET_SAMPLE;
	localparam logic [7:0] STS = `DAC_OFFSET_STATUS;
	localparam logic [7:0] IEN = `DAC_OFFSET_IRQ_ENABLE;
	logic aclk = 1'b0;
	logic aresetn = 1'b0;
	logic [1:0] src_div = 2'h0;
	logic req_d = 1'b0;
	int num_errors = 0;
	int checked = 0;
	int cycles = 0;
	wire logic awvalid, awready, wvalid, wready, bvalid, bready, arvalid, arready, rvalid, rready, irq, dma_req;
	wire logic [7:0] awaddr, araddr;
	wire logic [31:0] wdata, rdata;
	wire logic [3:0] wstrb;
	wire logic [1:0] bresp, rresp;
	wire dac_feed_pkg::channel_type left_sample, right_sample;

	stereo_bitstream_dac_feed #(.SAMPLE_DIVIDE(DIV), .ADDR_WIDTH(8)) u_stereo_bitstream_dac_feed (
		.aclk, .aresetn, .ce(1'b1), .sample_rate_clock(src_div[1]),
		.awvalid, .awready, .awaddr, .wvalid, .wready, .wdata, .wstrb, .bvalid, .bready, .bresp,
		.arvalid, .arready, .araddr, .rvalid, .rready, .rdata, .rresp,
		.left_sample, .right_sample, .irq, .dma_req
	);

	dac_feed_host u_dac_feed_host (
		.aclk, .awvalid, .awready, .awaddr, .wvalid, .wready, .wdata, .wstrb, .bvalid, .bready, .bresp,
		.arvalid, .arready, .araddr, .rvalid, .rready, .rdata, .rresp, .dma_req
	);

	always #2.5 aclk = ~aclk;

	// Sample clock runs from time zero, long before enable
	always @(posedge aclk) begin
		src_div <= src_div + 2'h1;
		req_d <= dma_req;
		cycles <= cycles + 1;
		if (cycles == 5000) begin
			num_errors++;
			tally_and_finish();
		end
	end

	task automatic tally_and_finish;
		if (num_errors == 0 && checked > 0) begin
			$display("[ PASS ]");
		end else begin
			$display("[ FAIL ]");
		end
		$finish;
	endtask

	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		logic [1:0] r;
		u_dac_feed_host.write(a, d, r);
	endtask

	task automatic rd_chk(input string n, input logic [7:0] a, input logic [31:0] e);
		logic [31:0] d;
		logic [1:0] r;
		u_dac_feed_host.read(a, d, r);
		`CHK(n, e, d)
	endtask

	// Edges counted up to the next rise of dma_req
	task automatic wait_req(output int n);
		n = 0;
		do begin
			@(posedge aclk);
			n++;
		end while (!(dma_req === 1'b1 && req_d === 1'b0));
	endtask

	task automatic check_reset;
		`CHK("left", 16'h0000, left_sample)
		`CHK("dma_req", 1'b0, dma_req)
		`CHK("irq", 1'b0, irq)
		rd_chk("control", CTL, `DAC_RESET_CONTROL);
		rd_chk("sample", SMP, `DAC_RESET_SAMPLE);
		rd_chk("status", STS, 32'h0000_0001);
		rd_chk("irq_enable", IEN, 32'h0000_0000);
	endtask

	task automatic sample_path;
		int n;
		wr(SMP, 32'h1234_ABCD);
		rd_chk("status written", STS, 32'h0000_0000);
		rd_chk("sample readback", SMP, 32'h1234_ABCD);
		wr(IEN, 32'h0000_0002);
		wr(CTL, 32'h0000_0001);
		wait_req(n);
		`CHK("left", 16'hABCD, left_sample)
		`CHK("right", 16'h1234, right_sample)
		`CHK("irq masked", 1'b0, irq)
		n = 0;
		while (irq !== 1'b1) begin
			@(posedge aclk);
			n++;
		end
		`CHK("underrun delay", 1'b1, n >= PER - 2 && n <= PER + 2)
		`CHK("left repeat", 16'hABCD, left_sample)
		rd_chk("status underrun", STS, 32'h0000_0003);
		wr(CTL, 32'h0000_0000);
		wr(STS, 32'h0000_0002);
		rd_chk("status cleared", STS, 32'h0000_0001);
		`CHK("irq cleared", 1'b0, irq)
		wr(IEN, 32'h0000_0001);
		@(posedge aclk);
		`CHK("irq tx_ready", 1'b1, irq)
		wr(IEN, 32'h0000_0000);
		@(posedge aclk);
		`CHK("irq off", 1'b0, irq)
	endtask

	task automatic unmapped;
		logic [1:0] r;
		logic [31:0] d;
		u_dac_feed_host.write(8'h10, 32'hFFFF_FFFF, r);
		`CHK("write resp", dac_feed_pkg::RESP_SLVERR, r)
		u_dac_feed_host.read(8'h10, d, r);
		`CHK("read resp", dac_feed_pkg::RESP_SLVERR, r)
		`CHK("read data", 32'h0000_0000, d)
	endtask

	// Bus handed to the DMA engine only once software is done
	task automatic dma_stream;
		int n;
		wr(SMP, 32'h5A5A_A5A5);
		wr(IEN, 32'h0000_0002);
		wr(CTL, 32'h0000_0001);
		u_dac_feed_host.dma_on = 1'b1;
		wait_req(n);
		`CHK("dma first", 16'hA5A5, left_sample)
		for (int k = 1; k <= 5; k++) begin
			wait_req(n);
			`CHK("dma period", PER, n)
			`CHK("dma left", 16'(k), left_sample)
			`CHK("dma right", 16'(k), right_sample)
		end
		`CHK("dma no underrun", 1'b0, irq)
		u_dac_feed_host.dma_lag = PER + 4;
		repeat (3 * PER) @(posedge aclk);
		`CHK("dma late underrun", 1'b1, irq)
		u_dac_feed_host.dma_on = 1'b0;
	endtask

	initial begin
		repeat (10) @(posedge aclk);
		aresetn <= 1'b1;
		check_reset();
		sample_path();
		unmapped();
		dma_stream();
		tally_and_finish();
	end
endmodule

`default_nettype wire
